// ===== rtl/scr_regs.sv
/*
 Register bank: configuration resolution fields, serial number, maker
 and part codes. Assumes a bus front end on clk that hands over written
 bytes (start marks the pointer byte) and pulls read bytes on rd_next.
*/
`timescale 1ns/1ps
`default_nettype none
module scr_regs
    import scr_pkg::*;
#(
    parameter logic [SCR_SERIAL_W-1:0] SERIAL = 41'h000_0000_0001,
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h005a  // Arbitrary value
)(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire scr_byte_type wr_byte,
    input  wire logic         rd_next,
    output logic        [7:0] rd_data,
    output logic        [7:0] pointer,
    output logic        [3:0] hum_bits,
    output logic        [3:0] temp_bits
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    scr_wstate_type wstate;
    scr_wstate_type next_wstate;
    logic [15:0]    config_word;
    logic [15:0]    next_config_word;
    logic [7:0]     next_pointer;
    logic [7:0]     wr_high;
    logic [7:0]     next_wr_high;
    logic           rd_low;
    logic           next_rd_low;
    logic [7:0]     next_rd_data;
    logic [15:0]    word;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        case (pointer)
            SCR_PTR_CONFIG:
                word = config_word;
            SCR_PTR_SERIAL_UPPER:
                word = SERIAL[SCR_SERIAL_W-1:SCR_UPPER_LO];
            SCR_PTR_SERIAL_MIDDLE:
                word = SERIAL[SCR_UPPER_LO-1:SCR_MIDDLE_LO];
            SCR_PTR_SERIAL_LOWER:
                word = {SERIAL[SCR_MIDDLE_LO-1:0],
                        {SCR_LOWER_PAD{1'b0}}};
            SCR_PTR_MAKER:
                word = MAKER_CODE;
            SCR_PTR_PART:
                word = PART_CODE;
            default:
                word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Byte sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_wstate      = wstate;
        next_config_word = config_word;
        next_pointer     = pointer;
        next_wr_high     = wr_high;
        next_rd_low      = rd_low;
        next_rd_data     = rd_data;
        if (wr_byte.valid) begin
            if (wr_byte.start) begin
                next_pointer = wr_byte.data;
                next_wstate  = SCR_HIGH;
                next_rd_low  = 1'b0;
            end else begin
                case (wstate)
                    SCR_HIGH: begin
                        next_wr_high = wr_byte.data;
                        next_wstate  = SCR_LOW;
                    end
                    SCR_LOW: begin
                        next_wstate = SCR_IDLE;
                        // Only resolution fields writable; ids ignore
                        if (pointer == SCR_PTR_CONFIG) begin
                            next_config_word =
                                {wr_high, wr_byte.data} & SCR_CONFIG_WMASK;
                        end
                    end
                    default: next_wstate = SCR_IDLE;
                endcase
            end
        end else if (rd_next) begin
            next_rd_data = rd_low ? word[7:0] : word[15:8];
            next_rd_low  = ~rd_low;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wstate      <= SCR_IDLE;
            config_word <= SCR_CONFIG_RESET;
            pointer     <= 8'h00;
            wr_high     <= 8'h00;
            rd_low      <= 1'b0;
            rd_data     <= 8'h00;
        end else begin
            wstate      <= next_wstate;
            config_word <= next_config_word;
            pointer     <= next_pointer;
            wr_high     <= next_wr_high;
            rd_low      <= next_rd_low;
            rd_data     <= next_rd_data;
        end
    end

    scr_resolution u_res (
        .hres_code (config_word[SCR_HRES_HI:SCR_HRES_LO]),
        .tres_code (config_word[SCR_TRES_BIT]),
        .hum_bits  (hum_bits),
        .temp_bits (temp_bits)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_hres_eight: assert property (@(posedge clk)
        disable iff (reset)
        config_word[SCR_HRES_HI:SCR_HRES_LO] == SCR_HRES_8
        |-> hum_bits == SCR_BITS_8)
        else $error("humidity 8 bit decode wrong");
    chk_hres_eleven: assert property (@(posedge clk)
        disable iff (reset)
        config_word[SCR_HRES_HI:SCR_HRES_LO] == SCR_HRES_11
        |-> hum_bits == SCR_BITS_11)
        else $error("humidity 11 bit decode wrong");
    chk_hres_fourteen: assert property (@(posedge clk)
        disable iff (reset)
        config_word[SCR_HRES_HI:SCR_HRES_LO] == SCR_HRES_14
        |-> hum_bits == SCR_BITS_14)
        else $error("humidity 14 bit decode wrong");
    chk_tres_eleven: assert property (@(posedge clk)
        disable iff (reset)
        config_word[SCR_TRES_BIT] |-> temp_bits == SCR_BITS_11)
        else $error("temperature 11 bit decode wrong");
    chk_tres_fourteen: assert property (@(posedge clk)
        disable iff (reset)
        !config_word[SCR_TRES_BIT] |-> temp_bits == SCR_BITS_14)
        else $error("temperature 14 bit decode wrong");
    chk_upper_read: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && !rd_low
        && pointer == SCR_PTR_SERIAL_UPPER
        |=> rd_data == SERIAL[SCR_SERIAL_W-1:SCR_SERIAL_W-8])
        else $error("upper serial byte wrong");
    chk_upper_low: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && rd_low
        && pointer == SCR_PTR_SERIAL_UPPER
        |=> rd_data == SERIAL[SCR_UPPER_LO+7:SCR_UPPER_LO])
        else $error("upper serial low byte wrong");
    chk_ro_write: assert property (@(posedge clk)
        disable iff (reset)
        wr_byte.valid && !wr_byte.start && wstate == SCR_LOW
        && pointer != SCR_PTR_CONFIG |=> $stable(config_word))
        else $error("write reached a read only register");
    chk_middle_read: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && rd_low
        && pointer == SCR_PTR_SERIAL_MIDDLE
        |=> rd_data == SERIAL[SCR_MIDDLE_LO+7:SCR_MIDDLE_LO])
        else $error("middle serial low byte wrong");
    chk_middle_high: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && !rd_low
        && pointer == SCR_PTR_SERIAL_MIDDLE
        |=> rd_data == SERIAL[SCR_UPPER_LO-1:SCR_UPPER_LO-8])
        else $error("middle serial high byte wrong");
    chk_lower_pad: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && rd_low
        && pointer == SCR_PTR_SERIAL_LOWER
        |=> rd_data == {SERIAL[0], 7'h00})
        else $error("lower serial pad not zero");
    chk_lower_high: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && !rd_low
        && pointer == SCR_PTR_SERIAL_LOWER
        |=> rd_data == SERIAL[SCR_MIDDLE_LO-1:1])
        else $error("lower serial high byte wrong");
    chk_maker_read: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && !rd_low && pointer == SCR_PTR_MAKER
        |=> rd_data == MAKER_CODE[15:8])
        else $error("maker code wrong");
    chk_maker_low: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && rd_low && pointer == SCR_PTR_MAKER
        |=> rd_data == MAKER_CODE[7:0])
        else $error("maker code low byte wrong");
    chk_part_read: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && rd_low && pointer == SCR_PTR_PART
        |=> rd_data == PART_CODE[7:0])
        else $error("part code wrong");
    chk_part_high: assert property (@(posedge clk)
        disable iff (reset)
        rd_next && !wr_byte.valid && !rd_low && pointer == SCR_PTR_PART
        |=> rd_data == PART_CODE[15:8])
        else $error("part code high byte wrong");
    chk_config_mask: assert property (@(posedge clk)
        disable iff (reset)
        (config_word & ~SCR_CONFIG_WMASK) == 16'h0000)
        else $error("config holds non resolution bits");
    chk_ptr_load: assert property (@(posedge clk)
        disable iff (reset)
        wr_byte.valid && wr_byte.start |=> pointer == $past(wr_byte.data)
        && !rd_low)
        else $error("pointer not loaded");
    chk_rd_hold: assert property (@(posedge clk)
        disable iff (reset)
        !rd_next || wr_byte.valid |=> $stable(rd_data))
        else $error("read byte moved without a fetch");
endmodule
`default_nettype wire

// ===== rtl/scr_pkg.sv
/*
 Package for the sensor configuration and identity register bank:
 register pointers, field positions, codes and the internal port struct.
 Assumes a byte-serial front end that delivers pointer and data bytes.
*/
package scr_pkg;
    // Register pointers
    localparam logic [7:0] SCR_PTR_CONFIG        = 8'h02;
    localparam logic [7:0] SCR_PTR_SERIAL_UPPER  = 8'hfb;
    localparam logic [7:0] SCR_PTR_SERIAL_MIDDLE = 8'hfc;
    localparam logic [7:0] SCR_PTR_SERIAL_LOWER  = 8'hfd;
    localparam logic [7:0] SCR_PTR_MAKER         = 8'hfe;
    localparam logic [7:0] SCR_PTR_PART          = 8'hff;

    // Configuration fields
    localparam int SCR_TRES_BIT = 10;
    localparam int SCR_HRES_HI  = 9;
    localparam int SCR_HRES_LO  = 8;
    localparam logic [15:0] SCR_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] SCR_CONFIG_WMASK = 16'h0700;

    // Serial number layout
    localparam int SCR_SERIAL_W   = 41;
    localparam int SCR_UPPER_LO   = 25;
    localparam int SCR_MIDDLE_LO  = 9;
    localparam int SCR_LOWER_PAD  = 7;

    // Resolution codes
    localparam logic [1:0] SCR_HRES_14 = 2'h0;
    localparam logic [1:0] SCR_HRES_11 = 2'h1;
    localparam logic [1:0] SCR_HRES_8  = 2'h2;
    localparam logic [3:0] SCR_BITS_14 = 4'he;
    localparam logic [3:0] SCR_BITS_11 = 4'hb;
    localparam logic [3:0] SCR_BITS_8  = 4'h8;

    typedef enum logic [1:0] {
        SCR_IDLE = 2'b00,
        SCR_HIGH = 2'b01,
        SCR_LOW  = 2'b10
    } scr_wstate_type;

    typedef struct packed {
        logic       valid;
        logic       start;
        logic [7:0] data;
    } scr_byte_type;
endpackage

// ===== rtl/scr_resolution.sv
/*
 Resolution decoder: turns configuration fields into conversion widths.
 Assumes the fields come from a register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module scr_resolution
    import scr_pkg::*;
(
    input  wire logic [1:0] hres_code,
    input  wire logic       tres_code,
    output logic      [3:0] hum_bits,
    output logic      [3:0] temp_bits
);
    always_comb begin
        case (hres_code)
            SCR_HRES_14: hum_bits = SCR_BITS_14;
            SCR_HRES_11: hum_bits = SCR_BITS_11;
            SCR_HRES_8:  hum_bits = SCR_BITS_8;
            default:     hum_bits = SCR_BITS_14;
        endcase
        temp_bits = tres_code ? SCR_BITS_11 : SCR_BITS_14;
    end
endmodule
`default_nettype wire

// ===== sim/scr_host.sv
/*
 Host model: sends pointer and data bytes, fetches read words.
 Assumes the register bank runs on the same clk.
*/
`timescale 1ns/1ps
`default_nettype none
module scr_host
    import scr_pkg::*;
(
    input  wire logic             clk,
    input  wire logic       [7:0] rd_data,
    output var  scr_byte_type     wr_byte,
    output var  logic             rd_next
);
    // No acquisitions are started, so none come too often
    initial begin
        wr_byte = '0;
        rd_next = 1'b0;
    end
    // Pointer byte, then high and low data bytes when with_data is set
    task automatic send(input logic [7:0] p, input logic [15:0] d,
                        input bit with_data);
        @(posedge clk) wr_byte <= '{1'b1, 1'b1, p};
        if (with_data) begin
            @(posedge clk) wr_byte <= '{1'b1, 1'b0, d[15:8]};
            @(posedge clk) wr_byte <= '{1'b1, 1'b0, d[7:0]};
        end
        // Released data shows the inverse of the last byte
        @(posedge clk) wr_byte <= {2'b00, ~wr_byte.data};
    endtask
    // Two fetches, high byte arrives first
    task automatic fetch(output logic [15:0] d);
        @(posedge clk) rd_next <= 1'b1;
        @(posedge clk);
        #1 d[15:8] = rd_data;
        @(posedge clk) rd_next <= 1'b0;
        #1 d[7:0] = rd_data;
    endtask
endmodule
`default_nettype wire

// ===== sim/test_scr_regs.sv
/*
 Testbench for the configuration and identity register bank.
 Assumes the host model scr_host and the package scr_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module test_scr_regs
    import scr_pkg::*;
;
    localparam logic [40:0] SER   = 41'h1_2345_6789_ab;
    localparam logic [15:0] MAKER = 16'h0c3a; // Arbitrary value
    localparam logic [15:0] PART  = 16'h00e7; // Arbitrary value
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    scr_byte_type wr_byte;
    logic         rd_next;
    logic   [7:0] rd_data, pointer, p;
    logic   [3:0] hum_bits, temp_bits;
    logic  [15:0] got, d, cfg;
    integer       seed = 58, err_total = 0, n_compared = 0, i;
    always #12.5 clk = ~clk;
    scr_regs #(.SERIAL(SER), .MAKER_CODE(MAKER), .PART_CODE(PART)) dut (
        .clk(clk), .reset(reset), .wr_byte(wr_byte), .rd_next(rd_next),
        .rd_data(rd_data), .pointer(pointer), .hum_bits(hum_bits),
        .temp_bits(temp_bits));
    scr_host host (.clk(clk), .rd_data(rd_data), .wr_byte(wr_byte),
        .rd_next(rd_next));
    function automatic logic [15:0] reg_exp(input logic [7:0] a);
        case (a)
            SCR_PTR_CONFIG: return cfg;
            8'hfb: return SER[40:25];
            8'hfc: return SER[24:9];
            8'hfd: return {SER[8:0], 7'h00};
            8'hfe: return MAKER;
            8'hff: return PART;
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] width_exp(input logic [15:0] c);
        logic [3:0] h;
        h = (c[9:8] == 2'h1) ? 4'hb : (c[9:8] == 2'h2) ? 4'h8 : 4'he;
        return {8'h00, h, c[10] ? 4'hb : 4'he};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic do_reset(input integer n);
        @(posedge clk) reset <= 1'b1;
        repeat (n) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk) #1;
        cfg = 16'h0000;
        check({8'h00, pointer}, 16'h0000);
        check({8'h00, rd_data}, 16'h0000);
        check({8'h00, hum_bits, temp_bits}, 16'h00ee);
        $display("reset test done");
    endtask
    task automatic read_at(input logic [7:0] a);
        host.send(a, 16'h0000, 1'b0);
        // Let the pointer load of this edge settle
        #1;
        check({8'h00, pointer}, {8'h00, a});
        host.fetch(got);
        check(got, reg_exp(a));
    endtask
    initial begin
        do_reset(20);
        for (i = 0; i < 16; i++) begin
            d = 16'($random(seed));
            if (i < 8)
                d[10:8] = i[2:0];
            host.send(SCR_PTR_CONFIG, d, 1'b1);
            cfg = d & SCR_CONFIG_WMASK;
            read_at(SCR_PTR_CONFIG);
            check({8'h00, hum_bits, temp_bits}, width_exp(cfg));
        end
        $display("config test done");
        for (i = 251; i < 256; i++) begin
            host.send(i[7:0], 16'($random(seed)), 1'b1);
            read_at(i[7:0]);
        end
        $display("read only test done");
        for (i = 0; i < 6; i++) begin
            p = 8'h03 + 8'($unsigned($random(seed)) % 248);
            read_at(p);
        end
        $display("unmapped test done");
        do_reset(2);
        read_at(8'hfd);
        $display("serial after reset test done");
        stop_test;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        stop_test;
    end
endmodule
`default_nettype wire
